// [core/pin_driven_watchdog_timer.sv]
// Top of the pin-driven watchdog: pin registers, LED mirror, reset out
//
// Functional notes
// - Enabled watchdog whose period expires without a kick asserts system reset.
// - Active-low enable bit comes up 1 at power-on, watchdog disabled.
// - Clearing enable bit 0 of level register 38h starts timing at chosen period.
// - Each select pin level is inverted at the timeout core's select input.
// - After self-test, select bits shown inverted on LED0 and LED1.
// - Kick bit shown inverted on self-test LED7.
// - Enable high disables; selects 11,10,01,00 give 100 ms, 1 s, 10 s, 1 min.
// - The four control pins default to output direction at power-on.
`timescale 1ns/1ps
`default_nettype none
module pin_driven_watchdog_timer #(
  parameter logic [31:0] CYCLES_100MS = 32'(wdt_pkg::CYC_100MS),
  parameter logic [31:0] CYCLES_1S = 32'(wdt_pkg::CYC_1S),
  parameter logic [31:0] CYCLES_10S = 32'(wdt_pkg::CYC_10S),
  parameter logic [31:0] CYCLES_1MIN = 32'(wdt_pkg::CYC_1MIN)
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [31:0] IO_WDATA,
  output logic [31:0] IO_RDATA,
  input wire logic SELF_TEST_DONE,
  output logic SYS_RESET_N,
  output logic LED_SEL_LOW,
  output logic LED_SEL_HIGH,
  output logic LED_KICK,
  output logic WDT_ACTIVE
);
  import wdt_pkg::*;

  logic [31:0] dir_b_reg;
  logic [31:0] lvl_b_reg;
  logic [31:0] dir_c_reg;
  logic [31:0] lvl_c_reg;
  logic done_meta_reg;
  logic done_sync_reg;
  logic [31:0] rdata_next;

  wdt_link_if link ();

  // A pin set as input floats to its pull-up
  function automatic logic pin_level(input logic [31:0] dir, input logic [31:0] lvl, input int idx);
    pin_level = dir[idx] ? 1'b1 : lvl[idx];
  endfunction : pin_level

  // Readback shows the level actually on each pin
  function automatic logic [31:0] pin_word(input logic [31:0] dir, input logic [31:0] lvl);
    pin_word = dir | lvl;
  endfunction : pin_word

  wire logic hit_dir_b = (IO_ADDR == OFS_DIR_B);
  wire logic hit_lvl_b = (IO_ADDR == OFS_LVL_B);
  wire logic hit_dir_c = (IO_ADDR == OFS_DIR_C);
  wire logic hit_lvl_c = (IO_ADDR == OFS_LVL_C);
  wire logic wr_dir_b = IO_WR && hit_dir_b;
  wire logic wr_lvl_b = IO_WR && hit_lvl_b;
  wire logic wr_dir_c = IO_WR && hit_dir_c;
  wire logic wr_lvl_c = IO_WR && hit_lvl_c;

  wire logic enable_pin = pin_level(dir_b_reg, lvl_b_reg, ENABLE_BIT);
  wire logic select_low_pin = pin_level(dir_b_reg, lvl_b_reg, SEL_LOW_BIT);
  wire logic select_high_pin = pin_level(dir_b_reg, lvl_b_reg, SEL_HIGH_BIT);
  wire logic kick_pin = pin_level(dir_c_reg, lvl_c_reg, KICK_BIT);

  assign link.enable_n = enable_pin;
  assign link.sel_low_in = ~select_low_pin;
  assign link.sel_high_in = ~select_high_pin;
  assign link.kick = kick_pin;

  always_comb begin
    rdata_next = RDATA_UNMAPPED;
    if (hit_dir_b) begin
      rdata_next = dir_b_reg;
    end else if (hit_lvl_b) begin
      rdata_next = pin_word(dir_b_reg, lvl_b_reg);
    end else if (hit_dir_c) begin
      rdata_next = dir_c_reg;
    end else if (hit_lvl_c) begin
      rdata_next = pin_word(dir_c_reg, lvl_c_reg);
    end
  end

  watchdog_chip #(
    .CYCLES_100MS(CYCLES_100MS),
    .CYCLES_1S(CYCLES_1S),
    .CYCLES_10S(CYCLES_10S),
    .CYCLES_1MIN(CYCLES_1MIN)
  ) watchdog_chip_inst (
    .clk(CLK),
    .nrst(NRST),
    .link(link)
  );

  // Pin registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dir_b_reg <= DIR_B_RESET;
      lvl_b_reg <= LVL_B_RESET;
      dir_c_reg <= DIR_C_RESET;
      lvl_c_reg <= LVL_C_RESET;
    end else begin
      if (wr_dir_b) begin
        dir_b_reg <= IO_WDATA;
      end
      if (wr_lvl_b) begin
        lvl_b_reg <= IO_WDATA;
      end
      if (wr_dir_c) begin
        dir_c_reg <= IO_WDATA;
      end
      if (wr_lvl_c) begin
        lvl_c_reg <= IO_WDATA;
      end
    end
  end

  // Self-test done comes from outside, synchronised first
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
    end else begin
      done_meta_reg <= SELF_TEST_DONE;
      done_sync_reg <= done_meta_reg;
    end
  end

  // Registered outputs; LEDs are active high
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      IO_RDATA <= RDATA_UNMAPPED;
      SYS_RESET_N <= 1'b1;
      LED_SEL_LOW <= 1'b0;
      LED_SEL_HIGH <= 1'b0;
      LED_KICK <= 1'b0;
      WDT_ACTIVE <= 1'b0;
    end else begin
      if (IO_RD) begin
        IO_RDATA <= rdata_next;
      end
      SYS_RESET_N <= ~link.fire;
      LED_SEL_LOW <= done_sync_reg & ~select_low_pin;
      LED_SEL_HIGH <= done_sync_reg & ~select_high_pin;
      LED_KICK <= done_sync_reg & ~kick_pin;
      WDT_ACTIVE <= ~enable_pin;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // Reset pin stays low for the whole pulse, then lets go
  sequence reset_pulse_s;
    !SYS_RESET_N [*8] ##1 SYS_RESET_N;
  endsequence

  // Reset output against the core's fire line
  AST_RESET_FOLLOWS_FIRE: assert property (link.fire |=> !SYS_RESET_N)
    else $error("system reset not asserted on fire");

  AST_NO_RESET_WITHOUT_FIRE: assert property (!link.fire |=> SYS_RESET_N)
    else $error("system reset without fire");

  AST_RESET_PULSE_EIGHT: assert property ($fell(SYS_RESET_N) |-> reset_pulse_s)
    else $error("system reset pulse has wrong width");

  AST_FIRE_NEEDS_ENABLE: assert property ($rose(link.fire) |-> !$past(enable_pin))
    else $error("fire started while enable pin high");

  AST_ACTIVE_FOLLOWS_ENABLE: assert property (1'b1 |=> WDT_ACTIVE == !$past(enable_pin))
    else $error("active flag does not follow enable pin");

  AST_INPUT_PIN_PULLS_UP: assert property (dir_b_reg[ENABLE_BIT] |=> !WDT_ACTIVE)
    else $error("enable pin set as input still enables");

  // Register port
  AST_ENABLE_ONLY_BY_WRITE: assert property ($fell(lvl_b_reg[ENABLE_BIT]) |-> $past(wr_lvl_b))
    else $error("enable bit cleared without a write");

  AST_LVL_B_WRITE_LANDS: assert property (wr_lvl_b |=> lvl_b_reg == $past(IO_WDATA))
    else $error("level b write did not land");

  AST_LVL_C_WRITE_LANDS: assert property (wr_lvl_c |=> lvl_c_reg == $past(IO_WDATA))
    else $error("level c write did not land");

  AST_DIR_B_WRITE_LANDS: assert property (wr_dir_b |=> dir_b_reg == $past(IO_WDATA))
    else $error("direction b write did not land");

  AST_DIR_C_WRITE_LANDS: assert property (wr_dir_c |=> dir_c_reg == $past(IO_WDATA))
    else $error("direction c write did not land");

  AST_LVL_B_READBACK: assert property (IO_RD && hit_lvl_b |=> IO_RDATA == ($past(dir_b_reg) | $past(lvl_b_reg)))
    else $error("level b readback is not the pin level");

  AST_UNMAPPED_READS_ZERO: assert property (IO_RD && !hit_dir_b && !hit_lvl_b && !hit_dir_c && !hit_lvl_c
      |=> IO_RDATA == RDATA_UNMAPPED)
    else $error("unmapped read returned data");

  AST_READ_DATA_HOLDS: assert property (!IO_RD |=> $stable(IO_RDATA))
    else $error("read data changed without a read");

  // Self-test LEDs
  AST_LED_SELECT_MIRROR: assert property (done_sync_reg |=> LED_SEL_LOW == !$past(select_low_pin)
      && LED_SEL_HIGH == !$past(select_high_pin))
    else $error("select LEDs do not mirror inverted bits");

  AST_LED_KICK_MIRROR: assert property (done_sync_reg |=> LED_KICK == !$past(kick_pin))
    else $error("kick LED does not mirror inverted bit");

  AST_LEDS_DARK_BEFORE_DONE: assert property (!done_sync_reg |=> !LED_SEL_LOW && !LED_SEL_HIGH && !LED_KICK)
    else $error("LEDs lit before self-test done");
endmodule : pin_driven_watchdog_timer
`default_nettype wire

// [core/watchdog_chip.sv]
// Timeout core: period decode, kick edge detect, reset pulse
`timescale 1ns/1ps
`default_nettype none
module watchdog_chip #(
  parameter logic [31:0] CYCLES_100MS = 32'h003D_0900,
  parameter logic [31:0] CYCLES_1S = 32'h0262_5A00,
  parameter logic [31:0] CYCLES_10S = 32'h17D7_8400,
  parameter logic [31:0] CYCLES_1MIN = 32'h8F0D_1800
) (
  input wire logic clk,
  input wire logic nrst,
  wdt_link_if.chip link
);
  import wdt_pkg::*;

  wdt_state_t state_reg, state_next;
  logic [31:0] count_reg, count_next;
  logic [PULSE_W-1:0] pulse_reg, pulse_next;
  logic kick_prev_reg;

  // Select inputs here are already inverted pin levels
  function automatic logic [31:0] period_cycles(input logic hi_in, input logic lo_in);
    case ({hi_in, lo_in})
      2'b00: period_cycles = CYCLES_100MS;
      2'b01: period_cycles = CYCLES_1S;
      2'b10: period_cycles = CYCLES_10S;
      default: period_cycles = CYCLES_1MIN;
    endcase
  endfunction : period_cycles

  wire logic [31:0] limit = period_cycles(link.sel_high_in, link.sel_low_in);
  wire logic kick_edge = link.kick ^ kick_prev_reg;
  wire logic expired = (state_reg == ST_RUN) && !kick_edge && (count_reg >= limit - COUNT_ONE);

  assign link.fire = (state_reg == ST_FIRE);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    pulse_next = PULSE_ZERO;
    case (state_reg)
      ST_OFF: begin
        count_next = COUNT_ZERO;
        if (!link.enable_n) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (link.enable_n) begin
          state_next = ST_OFF;
          count_next = COUNT_ZERO;
        end else if (kick_edge) begin
          count_next = COUNT_ZERO;
        end else if (expired) begin
          state_next = ST_FIRE;
          count_next = COUNT_ZERO;
        end else begin
          count_next = count_reg + COUNT_ONE;
        end
      end
      ST_FIRE: begin
        count_next = COUNT_ZERO;
        pulse_next = pulse_reg + 3'h1;
        if (pulse_reg == PULSE_LAST) begin
          pulse_next = PULSE_ZERO;
          state_next = link.enable_n ? ST_OFF : ST_RUN;
        end
      end
      default: begin
        state_next = ST_OFF;
        count_next = COUNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_OFF;
      count_reg <= COUNT_ZERO;
      pulse_reg <= PULSE_ZERO;
      kick_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      pulse_reg <= pulse_next;
      kick_prev_reg <= link.kick;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence fire_pulse_s;
    link.fire [*8] ##1 !link.fire;
  endsequence

  AST_DISABLED_NEVER_FIRES: assert property ((state_reg == ST_OFF) && link.enable_n |=> !link.fire)
    else $error("watchdog fired while disabled");
  AST_DISABLE_CLEARS_COUNT: assert property (link.enable_n && !link.fire |=> count_reg == COUNT_ZERO)
    else $error("count not cleared on disable");
  AST_KICK_RESTARTS: assert property ((state_reg == ST_RUN) && !link.enable_n && kick_edge |=> count_reg == COUNT_ZERO)
    else $error("kick edge did not restart count");
  AST_EXPIRY_FIRES: assert property (!link.enable_n && expired |=> fire_pulse_s)
    else $error("expiry did not give full reset pulse");
  AST_COUNT_BOUNDED: assert property ((state_reg == ST_RUN) |-> count_reg < limit)
    else $error("count passed selected period");
endmodule : watchdog_chip
`default_nettype wire

// [core/wdt_link_if.sv]
// Control lines between the pin logic and the timeout core
`timescale 1ns/1ps
`default_nettype none
interface wdt_link_if;
  logic enable_n;
  logic sel_low_in;
  logic sel_high_in;
  logic kick;
  logic fire;
  modport ctrl (output enable_n, output sel_low_in, output sel_high_in, output kick, input fire);
  modport chip (input enable_n, input sel_low_in, input sel_high_in, input kick, output fire);
endinterface : wdt_link_if
`default_nettype wire

// [core/wdt_pkg.sv]
// Constants for the pin-driven watchdog timer
package wdt_pkg;
  localparam logic [7:0] OFS_DIR_B = 8'h34;
  localparam logic [7:0] OFS_LVL_B = 8'h38;
  localparam logic [7:0] OFS_DIR_C = 8'h44;
  localparam logic [7:0] OFS_LVL_C = 8'h48;
  localparam int ENABLE_BIT = 0;
  localparam int SEL_LOW_BIT = 1;
  localparam int SEL_HIGH_BIT = 2;
  localparam int KICK_BIT = 7;
  localparam logic [31:0] DIR_B_RESET = 32'hFFFF_FFF8;
  localparam logic [31:0] LVL_B_RESET = 32'h0000_0001;
  localparam logic [31:0] DIR_C_RESET = 32'hFFFF_FF7F;
  localparam logic [31:0] LVL_C_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
  localparam longint unsigned CLK_HZ = 64'd40_000_000;
  localparam longint unsigned US_PER_S = 64'd1_000_000;
  localparam longint unsigned T_100MS_US = 64'd100_000;
  localparam longint unsigned T_1S_US = 64'd1_000_000;
  localparam longint unsigned T_10S_US = 64'd10_000_000;
  localparam longint unsigned T_1MIN_US = 64'd60_000_000;
  localparam longint unsigned CYC_100MS = T_100MS_US * CLK_HZ / US_PER_S;
  localparam longint unsigned CYC_1S = T_1S_US * CLK_HZ / US_PER_S;
  localparam longint unsigned CYC_10S = T_10S_US * CLK_HZ / US_PER_S;
  localparam longint unsigned CYC_1MIN = T_1MIN_US * CLK_HZ / US_PER_S;
  localparam int PULSE_W = 3;
  localparam logic [PULSE_W-1:0] PULSE_LAST = 3'h7;
  localparam logic [PULSE_W-1:0] PULSE_ZERO = 3'h0;
  localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_FIRE = 3'b100
  } wdt_state_t;
endpackage : wdt_pkg

// [tb/pin_driven_watchdog_timer_tb.sv]
// Self-checking bench for the pin-driven watchdog
`timescale 1ns/1ps
`default_nettype none
module pin_driven_watchdog_timer_tb;
  import wdt_pkg::*;
  localparam logic [31:0] P100 = 32'h0000_0014;
  localparam logic [31:0] P1S = 32'h0000_0028;
  localparam logic [31:0] P10S = 32'h0000_003C;
  localparam logic [31:0] P1M = 32'h0000_0050;
  logic clk, nrst, done, wr, rd, sys_reset_n, led_lo, led_hi, led_kick, wdt_active;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d, seed;
  int failures, comparisons, resets, n, w, r0;
  logic kb;
  wdt_host wdt_host_inst (.clk(clk), .io_addr(addr), .io_wr(wr), .io_rd(rd), .io_wdata(wdata), .io_rdata(rdata));
  pin_driven_watchdog_timer #(.CYCLES_100MS(P100), .CYCLES_1S(P1S), .CYCLES_10S(P10S), .CYCLES_1MIN(P1M))
    pin_driven_watchdog_timer_inst (.CLK(clk), .NRST(nrst), .IO_ADDR(addr), .IO_WR(wr), .IO_RD(rd),
    .IO_WDATA(wdata), .IO_RDATA(rdata), .SELF_TEST_DONE(done), .SYS_RESET_N(sys_reset_n),
    .LED_SEL_LOW(led_lo), .LED_SEL_HIGH(led_hi), .LED_KICK(led_kick), .WDT_ACTIVE(wdt_active));
  function automatic logic [31:0] per(input logic [1:0] s);
    case (s)
      2'b11: return P100;
      2'b10: return P1S;
      2'b01: return P10S;
      default: return P1M;
    endcase
  endfunction : per
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  always @(negedge sys_reset_n) begin
    if (nrst) begin
      resets++;
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    failures = 0;
    comparisons = 0;
    resets = 0;
    seed = 32'h0001_4127;
    nrst = 1'b0;
    done = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    wdt_host_inst.rd(OFS_DIR_B, d);
    chk(d, DIR_B_RESET);
    wdt_host_inst.rd(OFS_LVL_B, d);
    chk(d, DIR_B_RESET | LVL_B_RESET);
    wdt_host_inst.rd(OFS_DIR_C, d);
    chk(d, DIR_C_RESET);
    wdt_host_inst.wr(8'h50, rnd());
    wdt_host_inst.rd(8'h50, d);
    chk(d, RDATA_UNMAPPED);
    chk(32'(wdt_active), 32'h0000_0000);
    chk(32'({led_hi, led_lo, led_kick}), 32'h0000_0000);
    $display("test reset values done");
    done = 1'b1;
    wdt_host_inst.cfg();
    for (int s = 0; s < 4; s++) begin
      wdt_host_inst.start(2'(s));
      n = 0;
      while (sys_reset_n === 1'b1 && n < 400) begin
        @(negedge clk);
        n++;
      end
      chk(32'(n >= int'(per(2'(s))) - 1 && n <= int'(per(2'(s))) + 4), 32'h0000_0001);
      w = 0;
      while (sys_reset_n === 1'b0 && w < 20) begin
        @(negedge clk);
        w++;
      end
      chk(32'(w), 32'h0000_0008);
      chk(32'({led_hi, led_lo}), 32'(3 - s));
      wdt_host_inst.rmw(OFS_LVL_B, ENABLE_BIT, 1'b1);
    end
    $display("test periods done");
    wdt_host_inst.start(2'b11);
    r0 = resets;
    kb = 1'b0;
    for (int k = 0; k < 6; k++) begin
      repeat (rnd() % 8) @(posedge clk);
      kb = ~kb;
      wdt_host_inst.rmw(OFS_LVL_C, KICK_BIT, kb);
      @(negedge clk);
      @(negedge clk);
      chk(32'(led_kick), 32'(!kb));
    end
    chk(32'(resets), 32'(r0));
    repeat (40) @(negedge clk);
    chk(32'(resets), 32'(r0 + 1));
    wdt_host_inst.rmw(OFS_LVL_B, ENABLE_BIT, 1'b1);
    $display("test kick done");
    wdt_host_inst.start(2'b00);
    r0 = resets;
    repeat (40) @(negedge clk);
    chk(32'(wdt_active), 32'h0000_0001);
    wdt_host_inst.rmw(OFS_LVL_B, ENABLE_BIT, 1'b1);
    repeat (120) @(negedge clk);
    chk(32'(resets), 32'(r0));
    chk(32'(wdt_active), 32'h0000_0000);
    $display("test disable done");
    wdt_host_inst.wr(OFS_DIR_B, DIR_B_RESET | 32'h0000_0001);
    wdt_host_inst.rmw(OFS_LVL_B, ENABLE_BIT, 1'b0);
    repeat (3) @(negedge clk);
    chk(32'(wdt_active), 32'h0000_0000);
    wdt_host_inst.rmw(OFS_LVL_B, ENABLE_BIT, 1'b1);
    wdt_host_inst.cfg();
    $display("test direction done");
    summarize();
  end
endmodule : pin_driven_watchdog_timer_tb
`default_nettype wire

// [tb/wdt_host.sv]
// Host software model driving the pin register port
`timescale 1ns/1ps
`default_nettype none
module wdt_host (
  input wire logic clk,
  output logic [7:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [31:0] io_wdata,
  input wire logic [31:0] io_rdata
);
  import wdt_pkg::*;
  initial begin
    io_addr = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 32'h0000_0000;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1;
    d = io_rdata;
    io_rd = 1'b0;
  endtask : rd
  // Other bits written back as read
  task automatic rmw(input logic [7:0] a, input int b, input logic v);
    logic [31:0] d;
    rd(a, d);
    d[b] = v;
    wr(a, d);
  endtask : rmw
  task automatic cfg();
    logic [31:0] d;
    rd(OFS_DIR_B, d);
    d[2:0] = 3'h0;
    wr(OFS_DIR_B, d);
    rmw(OFS_DIR_C, 7, 1'b0);
  endtask : cfg
  // Disable, pick period, then enable
  task automatic start(input logic [1:0] sel);
    logic [31:0] d;
    rmw(OFS_LVL_B, ENABLE_BIT, 1'b1);
    rd(OFS_LVL_B, d);
    d[SEL_HIGH_BIT] = sel[1];
    d[SEL_LOW_BIT] = sel[0];
    wr(OFS_LVL_B, d);
    rmw(OFS_LVL_B, ENABLE_BIT, 1'b0);
  endtask : start
endmodule : wdt_host
`default_nettype wire
